// *** hdl/video_mux_pkg.sv ***
package video_mux_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h84;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_DRIVE_EN = 7;
  localparam int BIT_SOCKET_CHOICE = 6;
  localparam int BIT_DETECT_EN = 5;
  localparam int PRIO_HI = 4;
  localparam int PRIO_LO = 2;
  localparam int BIT_SOCKET1_MODE = 1;
  localparam int BIT_SOCKET0_MODE = 0;
  localparam int VIDEO_WIDTH = 16;
  localparam logic [2:0] FUNC_PRIMARY = 3'h0;
  localparam logic [2:0] FUNC_SECONDARY = 3'h1;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_A = 2'h1,
    SRC_B = 2'h3,
    SRC_EXT = 2'h2
  } source_t;

  typedef enum logic [2:0] {
    PRIO_A_B_E = 3'h0,
    PRIO_A_E_B = 3'h1,
    PRIO_B_A_E = 3'h2,
    PRIO_B_E_A = 3'h3,
    PRIO_E_A_B = 3'h4,
    PRIO_E_B_A = 3'h5
  } prio_t;
endpackage

// *** hdl/video_src_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface video_src_if;
  logic [2:0] prio;
  logic a_active;
  logic b_active;
  logic ext_active;
  video_mux_pkg::source_t pick;
  modport top (output prio, output a_active, output b_active, output ext_active, input pick);
  modport arb (input prio, input a_active, input b_active, input ext_active, output pick);
endinterface
`default_nettype wire

// *** hdl/video_priority_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_priority_pick (
  video_src_if.arb s
);
  logic [2:0] act;
  assign act = {s.ext_active, s.b_active, s.a_active};

  function automatic video_mux_pkg::source_t first3(
    input logic [2:0] av,
    input video_mux_pkg::source_t p0,
    input video_mux_pkg::source_t p1,
    input video_mux_pkg::source_t p2
  );
    video_mux_pkg::source_t r;
    r = video_mux_pkg::SRC_NONE;
    if (av[2]) begin
      r = p2;
    end
    if (av[1]) begin
      r = p1;
    end
    if (av[0]) begin
      r = p0;
    end
    return r;
  endfunction

  always_comb begin
    s.pick = video_mux_pkg::SRC_NONE;
    unique case (s.prio)
      video_mux_pkg::PRIO_A_B_E: begin
        s.pick = first3({act[2], act[1], act[0]}, video_mux_pkg::SRC_A, video_mux_pkg::SRC_B, video_mux_pkg::SRC_EXT);
      end
      video_mux_pkg::PRIO_A_E_B: begin
        s.pick = first3({act[1], act[2], act[0]}, video_mux_pkg::SRC_A, video_mux_pkg::SRC_EXT, video_mux_pkg::SRC_B);
      end
      video_mux_pkg::PRIO_B_A_E: begin
        s.pick = first3({act[2], act[0], act[1]}, video_mux_pkg::SRC_B, video_mux_pkg::SRC_A, video_mux_pkg::SRC_EXT);
      end
      video_mux_pkg::PRIO_B_E_A: begin
        s.pick = first3({act[0], act[2], act[1]}, video_mux_pkg::SRC_B, video_mux_pkg::SRC_EXT, video_mux_pkg::SRC_A);
      end
      video_mux_pkg::PRIO_E_A_B: begin
        s.pick = first3({act[1], act[0], act[2]}, video_mux_pkg::SRC_EXT, video_mux_pkg::SRC_A, video_mux_pkg::SRC_B);
      end
      video_mux_pkg::PRIO_E_B_A: begin
        s.pick = first3({act[0], act[1], act[2]}, video_mux_pkg::SRC_EXT, video_mux_pkg::SRC_B, video_mux_pkg::SRC_A);
      end
      // Reserved codes route nothing
      default: begin
        s.pick = video_mux_pkg::SRC_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** hdl/video_port_source_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_port_source_mux (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_HIT,
  input wire logic [15:0] CARD0_VIDEO,
  input wire logic [15:0] CARD1_VIDEO,
  input wire logic [15:0] EXT_VIDEO,
  input wire logic CARD0_ACTIVE,
  input wire logic CARD1_ACTIVE,
  input wire logic EXT_ACTIVE,
  output logic [15:0] VIDEO_OUT,
  output logic VIDEO_OUT_OE,
  output logic SOCKET0_VIDEO_IN_EN,
  output logic SOCKET1_VIDEO_IN_EN,
  output logic [1:0] ROUTED_SOURCE
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic func_ok;
  logic addr_hit;
  logic wr_hit;

  // Visible in both functions
  assign func_ok = (CFG_FUNC == video_mux_pkg::FUNC_PRIMARY) || (CFG_FUNC == video_mux_pkg::FUNC_SECONDARY);
  assign addr_hit = func_ok && (CFG_ADDR == video_mux_pkg::CTRL_OFFSET);
  assign wr_hit = CFG_WR && addr_hit;
  assign ctrl_nxt = wr_hit ? CFG_WDATA : ctrl_r;
  assign CFG_HIT = (CFG_WR || CFG_RD) && addr_hit;
  assign CFG_RDATA = (CFG_RD && addr_hit) ? ctrl_r : 8'h00;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_r <= video_mux_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for activity flags
  logic [2:0] act_meta_r;
  logic [2:0] act_sync_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      act_meta_r <= 3'h0;
      act_sync_r <= 3'h0;
    end else begin
      act_meta_r <= {EXT_ACTIVE, CARD1_ACTIVE, CARD0_ACTIVE};
      act_sync_r <= act_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  logic drive_en;
  logic socket_choice;
  logic detect_en;
  logic socket0_mode;
  logic socket1_mode;
  logic drive_ok;
  video_mux_pkg::source_t manual_src;
  video_mux_pkg::source_t sel_src;
  video_src_if src_if ();

  assign drive_en = ctrl_r[video_mux_pkg::BIT_DRIVE_EN];
  assign socket_choice = ctrl_r[video_mux_pkg::BIT_SOCKET_CHOICE];
  assign detect_en = ctrl_r[video_mux_pkg::BIT_DETECT_EN];
  assign socket1_mode = ctrl_r[video_mux_pkg::BIT_SOCKET1_MODE];
  assign socket0_mode = ctrl_r[video_mux_pkg::BIT_SOCKET0_MODE];

  assign src_if.prio = detect_en ? ctrl_r[video_mux_pkg::PRIO_HI:video_mux_pkg::PRIO_LO] : 3'h0;
  assign src_if.a_active = act_sync_r[0];
  assign src_if.b_active = act_sync_r[1];
  assign src_if.ext_active = act_sync_r[2];

  video_priority_pick u_pick (
    .s(src_if)
  );

  assign manual_src = socket_choice ? video_mux_pkg::SRC_B : video_mux_pkg::SRC_A;
  assign sel_src = detect_en ? src_if.pick : manual_src;
  assign drive_ok = drive_en && !socket0_mode && !socket1_mode;
  assign SOCKET0_VIDEO_IN_EN = socket0_mode;
  assign SOCKET1_VIDEO_IN_EN = socket1_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Registered output stage
  logic [15:0] data_nxt;
  logic [15:0] video_r;
  logic oe_r;
  logic [1:0] routed_r;
  video_mux_pkg::source_t route_nxt;

  assign route_nxt = drive_ok ? sel_src : video_mux_pkg::SRC_NONE;
  assign data_nxt = (route_nxt == video_mux_pkg::SRC_A) ? CARD0_VIDEO :
                    (route_nxt == video_mux_pkg::SRC_B) ? CARD1_VIDEO :
                    (route_nxt == video_mux_pkg::SRC_EXT) ? EXT_VIDEO : 16'h0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      video_r <= 16'h0000;
      oe_r <= 1'b0;
      routed_r <= 2'h0;
    end else begin
      video_r <= data_nxt;
      oe_r <= drive_ok && (route_nxt != video_mux_pkg::SRC_NONE);
      routed_r <= route_nxt;
    end
  end

  assign VIDEO_OUT = video_r;
  assign VIDEO_OUT_OE = oe_r;
  assign ROUTED_SOURCE = routed_r;
endmodule
`default_nettype wire

// *** verification/video_port_source_mux_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_port_source_mux_monitor (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic CFG_HIT,
  input wire logic VIDEO_OUT_OE,
  input wire logic SOCKET0_VIDEO_IN_EN,
  input wire logic SOCKET1_VIDEO_IN_EN,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic [7:0] CFG_RDATA,
  input wire logic [15:0] CARD0_VIDEO,
  input wire logic [15:0] CARD1_VIDEO,
  input wire logic [15:0] EXT_VIDEO,
  input wire logic [15:0] VIDEO_OUT,
  input wire logic [1:0] ROUTED_SOURCE
);
  // Last value accepted by the control register
  logic [7:0] last_wr_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      last_wr_r <= 8'h00;
    end else if (CFG_WR && CFG_HIT) begin
      last_wr_r <= CFG_WDATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  hit_decode_a: assert property (CFG_HIT == ((CFG_WR || CFG_RD) && CFG_FUNC < 3'h2 && CFG_ADDR == 8'h84))
    else $error("bad hit");
  reg_readback_a: assert property (CFG_RD && CFG_HIT |-> CFG_RDATA == last_wr_r)
    else $error("bad readback");
  mode_follow_a: assert property (CFG_WR && CFG_HIT |=>
    {SOCKET1_VIDEO_IN_EN, SOCKET0_VIDEO_IN_EN} == $past(CFG_WDATA[1:0])) else $error("bad mode bits");
  mode_quiet_a: assert property (SOCKET0_VIDEO_IN_EN || SOCKET1_VIDEO_IN_EN |=> !VIDEO_OUT_OE)
    else $error("drives in mode");
  float_quiet_a: assert property (!VIDEO_OUT_OE |-> VIDEO_OUT == 16'h0000 && ROUTED_SOURCE == 2'h0)
    else $error("floating not quiet");
  card0_data_a: assert property (ROUTED_SOURCE == 2'h1 |-> VIDEO_OUT == $past(CARD0_VIDEO))
    else $error("bad card0 data");
  card1_data_a: assert property (ROUTED_SOURCE == 2'h3 |-> VIDEO_OUT == $past(CARD1_VIDEO))
    else $error("bad card1 data");
  ext_data_a: assert property (ROUTED_SOURCE == 2'h2 |-> VIDEO_OUT == $past(EXT_VIDEO))
    else $error("bad ext data");
  cover property (ROUTED_SOURCE == 2'h2);
  cover property (VIDEO_OUT_OE && ROUTED_SOURCE == 2'h3);
  cover property (CFG_WR && CFG_HIT && CFG_FUNC == 3'h1);
endmodule
bind video_port_source_mux video_port_source_mux_monitor mon (.*);
`default_nettype wire

// *** verification/video_sources_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_sources_model (
  input wire logic clk,
  input wire logic [2:0] want,
  output logic [47:0] data = 48'h0000_0000_0000,
  output logic [2:0] act = 3'h0
);
  // Sources never go quiet, so stale data cannot hide a routing slip
  always @(negedge clk) begin
    data <= {16'($urandom), 16'($urandom), 16'($urandom)};
    act <= want;
  end
endmodule
`default_nettype wire

// *** verification/video_port_source_mux_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_port_source_mux_test;
  logic clk = 0, rst = 1, wr = 0, rd = 0, oe, hit, en0, en1;
  logic [2:0] func = 3'h0, want = 3'h0, act;
  logic [7:0] addr = 8'h84, wdata = 8'h00, rdata, d;
  logic [15:0] vout;
  logic [47:0] data, seen;
  logic [1:0] src;
  logic [4:0] e;
  logic [7:0] rq[$];
  logic [4:0] vq[$];
  logic [5:0] ord [6] = '{6'h1E, 6'h1B, 6'h36, 6'h39, 6'h27, 6'h2D};
  logic [7:0] man [8] = '{8'h00, 8'h80, 8'hC0, 8'h81, 8'hC2, 8'h9C, 8'hE3, 8'h7F};
  int error_cnt = 0, n_compared = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  video_sources_model srcs (.clk(clk), .want(want), .data(data), .act(act));
  video_port_source_mux dut (.CLK(clk), .RST(rst), .CFG_WR(wr), .CFG_RD(rd), .CFG_FUNC(func), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_HIT(hit), .CARD0_VIDEO(data[15:0]), .CARD1_VIDEO(data[31:16]),
    .EXT_VIDEO(data[47:32]), .CARD0_ACTIVE(act[0]), .CARD1_ACTIVE(act[1]), .EXT_ACTIVE(act[2]), .VIDEO_OUT(vout),
    .VIDEO_OUT_OE(oe), .SOCKET0_VIDEO_IN_EN(en0), .SOCKET1_VIDEO_IN_EN(en1), .ROUTED_SOURCE(src));
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  // One config cycle; for a read, v is the expected data
  task cyc(input logic w, input logic [2:0] f, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    {wr, rd, func, addr, wdata} = {w, !w, f, a, v};
    if (!w) rq.push_back(v);
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  function automatic logic [4:0] route(input logic [7:0] c, input logic [2:0] a);
    logic [1:0] s;
    logic [1:0] t;
    s = c[6] ? 2'h3 : 2'h1;
    if (c[5]) begin
      s = 2'h0;
      for (int i = 0; i < 3; i++) begin
        t = ord[c[4:2]][5 - 2 * i -: 2];
        if (c[4:2] < 3'h6 && s == 2'h0 && a[t == 2'h1 ? 0 : (t == 2'h3 ? 1 : 2)]) s = t;
      end
    end
    if (!c[7] || c[1:0] != 2'h0) s = 2'h0;
    route = {s != 2'h0, s, c[1:0]};
  endfunction
  task look(input logic [7:0] c, input logic [2:0] a);
    want = a;
    cyc(1, 3'h0, 8'h84, c);
    repeat (5) @(negedge clk);
    vq.push_back(route(c, a));
  endtask
  always @(posedge clk) begin
    if (rd && rq.size() != 0) chk(rdata, rq.pop_front());
    if (rd || wr) chk(hit, addr == 8'h84 && func < 3'h2);
    if (vq.size() != 0) begin
      e = vq.pop_front();
      chk({oe, src, en1, en0}, e);
      chk(vout, e[3:2] == 2'h1 ? seen[15:0] : e[3:2] == 2'h3 ? seen[31:16] : e[3:2] == 2'h2 ? seen[47:32] : 0);
    end
    seen = data;
  end
  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(94691));
    repeat (6) @(negedge clk);
    rst = 0;
    cyc(0, 3'h0, 8'h84, 8'h00);
    look(8'h00, 3'h7);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      cyc(1, 3'(i % 2), 8'h84, d);
      cyc(1, 3'h2, 8'h84, ~d);
      cyc(1, 3'h0, 8'h85, ~d);
      cyc(0, 3'h0, 8'h84, d);
      cyc(0, 3'h1, 8'h84, d);
      cyc(0, 3'h0, 8'h86, 8'h00);
    end
    rst = 1;
    @(negedge clk);
    rst = 0;
    cyc(0, 3'h0, 8'h84, 8'h00);
    $display("register test done");
    foreach (man[i]) look(man[i], 3'($urandom));
    $display("manual test done");
    for (int i = 0; i < 64; i++) look({3'b101, 3'(i >> 3), 2'b00}, 3'(i));
    $display("autodetect test done");
    finish_test();
  end
endmodule
`default_nettype wire
